// >>> pkg/erbcs_defines.svh
`ifndef ERBCS_DEFINES_SVH
`define ERBCS_DEFINES_SVH

// Register base offsets; each base owns four words: write, clear, set, invert.
`define ERBCS_OFF_STATUS 8'h00
`define ERBCS_OFF_CONTROL 8'h10
`define ERBCS_OFF_RXSTART 8'h20
`define ERBCS_OFF_STATION 8'h30
`define ERBCS_OFF_IRQ_STAT 8'h40
`define ERBCS_OFF_IRQ_EN 8'h50
`define ERBCS_OFF_IRQ_CLR 8'h60

// Field positions in the controller status register.
`define ERBCS_STAT_CNT_LSB 16
`define ERBCS_STAT_MOD_BIT 7
`define ERBCS_STAT_TX_BIT 6
`define ERBCS_STAT_RX_BIT 5

// Field positions in the control register.
`define ERBCS_CTL_ON_BIT 15
`define ERBCS_CTL_AFC_BIT 1
`define ERBCS_CTL_DEC_BIT 0

// Interrupt bits: packet pending, count saturated, reception halted.
`define ERBCS_IRQ_PEND_BIT 0
`define ERBCS_IRQ_SAT_BIT 1
`define ERBCS_IRQ_HALT_BIT 2
`define ERBCS_IRQ_W 3

// Reset values.
`define ERBCS_RST_CONTROL 32'h0000_0000
`define ERBCS_RST_RXSTART 32'h0000_0000
`define ERBCS_RST_IRQ_EN 3'h0

`endif

// >>> pkg/erbcs_pkg.sv
package erbcs_pkg;

  // Kind of write selected by the alias word of a register block.
  typedef enum logic [1:0] {
    ERBCS_OP_WRITE = 2'h0,
    ERBCS_OP_CLEAR = 2'h1,
    ERBCS_OP_SET = 2'h2,
    ERBCS_OP_INVERT = 2'h3
  } erbcs_alias_t;

endpackage

// >>> core/erbcs_buf_counter.sv
`timescale 1ns/10ps
// Saturating receive buffer counter.
module erbcs_buf_counter #(
  parameter int CNT_W = 8,
  parameter int INC_W = 4
) (
  // Clock and control.
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  // Count requests.
  input wire logic inc_valid,
  input wire logic [INC_W-1:0] inc_amount,
  input wire logic dec_req,
  input wire logic clear_req,
  // Count state.
  output logic [CNT_W-1:0] count,
  output logic at_max,
  output logic nonzero
);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic [CNT_W:0] sum; // One extra bit shows an overflow.

  // Next count; a clear beats every request.
  always_comb begin
    sum = {1'b0, count_r} + (CNT_W + 1)'(inc_amount);
    count_nxt = count_r;
    if (clear_req) begin
      count_nxt = '0;
    end else if (inc_valid && dec_req) begin
      count_nxt = count_r;
    end else if (inc_valid) begin
      count_nxt = sum[CNT_W] ? CNT_MAX : sum[CNT_W-1:0];
    end else if (dec_req) begin
      count_nxt = (count_r == '0) ? '0 : count_r - 1'b1;
    end
  end

  // The count does not depend on the module on bit, so it survives turn-off.
  always_ff @(posedge clock) begin
    if (reset) begin
      count_r <= '0;
    end else if (ce) begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;
  assign at_max = (count_r == CNT_MAX);
  assign nonzero = (count_r != '0);
endmodule

// >>> core/erbcs_busy_flags.sv
`timescale 1ns/10ps
// Module, transmit and receive activity flags.
module erbcs_busy_flags (
  // Clock and control.
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  // Activity inputs.
  input wire logic module_on,
  input wire logic transaction_pending,
  input wire logic tx_activity,
  input wire logic rx_activity,
  // Registered flags.
  output logic module_active_flag,
  output logic transmit_active_flag,
  output logic receive_active_flag
);
  logic mod_r;
  logic tx_r;
  logic rx_r;

  // Module flag stays up after turn-off until the open transaction ends.
  always_ff @(posedge clock) begin
    if (reset) begin
      mod_r <= 1'b0;
    end else if (ce) begin
      mod_r <= module_on || transaction_pending;
    end
  end

  // Each direction flag follows only its own activity and is off while disabled.
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_r <= 1'b0;
      rx_r <= 1'b0;
    end else if (ce) begin
      tx_r <= module_on && tx_activity;
      rx_r <= module_on && rx_activity;
    end
  end

  assign module_active_flag = mod_r;
  assign transmit_active_flag = tx_r;
  assign receive_active_flag = rx_r;
endmodule

// >>> core/erbcs_top.sv
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/10ps
`include "erbcs_defines.svh"
// Contract
// - Count rises by descriptors per received packet.
// - Increment at maximum leaves count unchanged.
// - Decrement at zero leaves count zero.
// - Simultaneous increment and decrement hold count.
// - Flow control halts reception at maximum.
// - Without flow control, count stays saturated.
// - Nonzero count sets pending; enable gates interrupt.
// - Start address write clears count.
// - Turning module off keeps the count.
// - Module flag follows on, then transaction.
// - Transmit flag follows transmit activity only.
// - Receive flag follows receive activity only.
// - Direction flags forced low while off.
// - Station octet one low, two above.
// - Station address preset from factory value.
// - Halfword and word accesses; byte ignored.
module erbcs_top #(
  parameter int CNT_W = 8,
  parameter int INC_W = 4
) (
  // Clock, reset and clock enable.
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  // APB register port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Factory station address, sampled during reset.
  input wire logic [15:0] factory_station_address,
  // Receive DMA side.
  input wire logic rx_packet_done,
  input wire logic [INC_W-1:0] rx_descriptors_used,
  output logic rx_halt,
  output logic [31:0] rx_descriptor_start_address,
  // Activity reports from the rest of the controller.
  input wire logic transaction_pending,
  input wire logic tx_activity,
  input wire logic rx_activity,
  // Configuration and status toward the controller.
  output logic module_on,
  output logic [15:0] station_address,
  output logic packet_pending_flag,
  // Interrupt request, level.
  output logic irq
);

  // Bus phase decode.
  logic setup_ph; // First cycle of a transfer.
  logic access_ph; // Completing cycle of a transfer.
  logic wr_take; // A mapped write completes this edge.
  logic [7:0] base; // Register block base of the address.
  erbcs_pkg::erbcs_alias_t op; // Alias selected by the address.
  logic mapped; // Address hits a register word.
  logic size_ok; // Halfword or word strobe pattern.
  logic [31:0] wmask; // Byte strobes widened to bits.

  // Register state.
  logic [31:0] ctl_r; // Control register.
  logic [31:0] rxst_r; // Descriptor start address.
  logic [15:0] sta_r; // Station address octets one and two.
  logic [`ERBCS_IRQ_W-1:0] ien_r; // Interrupt enables.
  logic [`ERBCS_IRQ_W-1:0] ist_r; // Sticky interrupt status.
  logic [`ERBCS_IRQ_W-1:0] ist_nxt;
  logic [`ERBCS_IRQ_W-1:0] ev; // Events of this cycle.
  logic [`ERBCS_IRQ_W-1:0] iclr; // Bits cleared by software.
  logic [31:0] rdata_nxt; // Read value for the setup cycle.
  logic [31:0] prdata_r;
  logic dec_pulse; // Software decrement request.
  logic clr_cnt; // Descriptor start address was written.
  logic at_max_d; // Count was saturated last cycle.

  // Counter and flag wires.
  logic [CNT_W-1:0] cnt;
  logic cnt_max;
  logic cnt_nz;
  logic mod_flag;
  logic tx_flag;
  logic rx_flag;

  // Applies one alias operation to a register value under a bit mask.
  function automatic logic [31:0] alias_apply(
    input erbcs_pkg::erbcs_alias_t o,
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [31:0] m
  );
    logic [31:0] res;
    begin
      case (o)
        erbcs_pkg::ERBCS_OP_WRITE: res = (old & ~m) | (wd & m);
        erbcs_pkg::ERBCS_OP_CLEAR: res = old & ~(wd & m);
        erbcs_pkg::ERBCS_OP_SET: res = old | (wd & m);
        erbcs_pkg::ERBCS_OP_INVERT: res = old ^ (wd & m);
        default: res = old;
      endcase
      alias_apply = res;
    end
  endfunction

  // Tells whether address a falls in the register block at base b, for reads and writes alike.
  function automatic logic hit(
    input logic [7:0] a,
    input logic [7:0] b
  );
    begin
      hit = (a[7:4] == b[7:4]);
    end
  endfunction

  // Address split: the upper nibble picks the block, bits 3:2 the alias.
  always_comb begin
    base = {paddr[7:4], 4'h0};
    op = erbcs_pkg::erbcs_alias_t'(paddr[3:2]);
    mapped = (paddr[1:0] == 2'h0) &&
             (hit(paddr, `ERBCS_OFF_STATUS) ||
              hit(paddr, `ERBCS_OFF_CONTROL) ||
              hit(paddr, `ERBCS_OFF_RXSTART) ||
              hit(paddr, `ERBCS_OFF_STATION) ||
              hit(paddr, `ERBCS_OFF_IRQ_STAT) ||
              hit(paddr, `ERBCS_OFF_IRQ_EN) ||
              hit(paddr, `ERBCS_OFF_IRQ_CLR));
  end

  // Only whole halfwords or the whole word count as a legal write size.
  always_comb begin
    size_ok = (pstrb == 4'hf) || (pstrb == 4'h3) || (pstrb == 4'hc);
    wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  // The slave never inserts wait states; a frozen clock enable holds it.
  // The error response covers only unmapped or unaligned words. A refused byte
  // write still completes cleanly, so software sees no fault for it.
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign pready = access_ph && ce;
  assign pslverr = access_ph && ce && !mapped;
  assign wr_take = access_ph && ce && pwrite && mapped;

  // A byte write is dropped silently rather than flagged as an error.
  assign clr_cnt = wr_take && size_ok && hit(paddr, `ERBCS_OFF_RXSTART);

  // Control register; the decrement bit never stays stored.
  // Writes through any of the four alias words land here, and the stored copy
  // of the decrement bit is masked so that it always reads back as zero.
  always_ff @(posedge clock) begin
    if (reset) begin
      ctl_r <= `ERBCS_RST_CONTROL;
    end else if (ce) begin
      if (wr_take && size_ok && hit(paddr, `ERBCS_OFF_CONTROL)) begin
        ctl_r <= alias_apply(op, ctl_r, pwdata, wmask) &
                 ~(32'h1 << `ERBCS_CTL_DEC_BIT);
      end
    end
  end

  // A written one in the decrement bit, through any alias but clear, is one request.
  // Two decrements need two writes, because a stored bit would repeat itself.
  always_comb begin
    dec_pulse = 1'b0;
    if (wr_take && size_ok && hit(paddr, `ERBCS_OFF_CONTROL) &&
        op != erbcs_pkg::ERBCS_OP_CLEAR) begin
      dec_pulse = pwdata[`ERBCS_CTL_DEC_BIT] && pstrb[0];
    end
  end

  // Descriptor start address; the low two bits stay zero for word alignment.
  // Every accepted write, through any alias, also empties the buffer count.
  always_ff @(posedge clock) begin
    if (reset) begin
      rxst_r <= `ERBCS_RST_RXSTART;
    end else if (ce) begin
      if (clr_cnt) begin
        rxst_r <= alias_apply(op, rxst_r, pwdata, wmask) & 32'hffff_fffc;
      end
    end
  end

  // Station address is preset from the factory value while reset is held.
  // Only two octets live here, so the upper half of the alias result is cut
  // off on purpose and never stored.
  always_ff @(posedge clock) begin
    if (reset) begin
      sta_r <= factory_station_address;
    end else if (ce) begin
      if (wr_take && size_ok && hit(paddr, `ERBCS_OFF_STATION)) begin
        sta_r <= 16'(alias_apply(op, {16'h0, sta_r}, pwdata, wmask));
      end
    end
  end

  // Interrupt enable register.
  // The alias result is cut to the implemented enable bits.
  always_ff @(posedge clock) begin
    if (reset) begin
      ien_r <= `ERBCS_RST_IRQ_EN;
    end else if (ce) begin
      if (wr_take && size_ok && hit(paddr, `ERBCS_OFF_IRQ_EN)) begin
        ien_r <= (`ERBCS_IRQ_W)'(alias_apply(op, {29'h0, ien_r}, pwdata, wmask));
      end
    end
  end

  // Saturation is an edge event so a full count raises it only once.
  always_ff @(posedge clock) begin
    if (reset) begin
      at_max_d <= 1'b0;
    end else if (ce) begin
      at_max_d <= cnt_max;
    end
  end

  // Events of this cycle and the bits software asks to clear.
  // The pending event is a level, so clearing it while packets wait has no
  // lasting effect; software must drain the count first.
  always_comb begin
    ev = '0;
    ev[`ERBCS_IRQ_PEND_BIT] = cnt_nz;
    ev[`ERBCS_IRQ_SAT_BIT] = cnt_max && !at_max_d;
    ev[`ERBCS_IRQ_HALT_BIT] = rx_halt && !at_max_d;
    iclr = '0;
    if (wr_take && size_ok && hit(paddr, `ERBCS_OFF_IRQ_CLR)) begin
      iclr = pwdata[`ERBCS_IRQ_W-1:0] & wmask[`ERBCS_IRQ_W-1:0];
    end
    // A new event in the clearing cycle keeps its bit set.
    ist_nxt = (ist_r & ~iclr) | ev;
  end

  // Sticky interrupt status; pending re-sets every cycle the count is nonzero.
  always_ff @(posedge clock) begin
    if (reset) begin
      ist_r <= '0;
    end else if (ce) begin
      ist_r <= ist_nxt;
    end
  end

  // The interrupt is a level of enabled sticky bits.
  assign irq = |(ist_r & ien_r);

  // Read multiplexer; aliases read back the base register.
  always_comb begin
    rdata_nxt = 32'h0;
    case (base)
      `ERBCS_OFF_STATUS: begin
        rdata_nxt[`ERBCS_STAT_CNT_LSB +: 8] = 8'(cnt);
        rdata_nxt[`ERBCS_STAT_MOD_BIT] = mod_flag;
        rdata_nxt[`ERBCS_STAT_TX_BIT] = tx_flag;
        rdata_nxt[`ERBCS_STAT_RX_BIT] = rx_flag;
      end
      `ERBCS_OFF_CONTROL: begin
        rdata_nxt = ctl_r;
      end
      `ERBCS_OFF_RXSTART: begin
        rdata_nxt = rxst_r;
      end
      `ERBCS_OFF_STATION: begin
        rdata_nxt = {16'h0, sta_r};
      end
      `ERBCS_OFF_IRQ_STAT: begin
        rdata_nxt[`ERBCS_IRQ_W-1:0] = ist_r;
      end
      `ERBCS_OFF_IRQ_EN: begin
        rdata_nxt[`ERBCS_IRQ_W-1:0] = ien_r;
      end
      default: begin
        rdata_nxt = 32'h0;
      end
    endcase
  end

  // Read data is captured in the setup cycle so it comes from a flop.
  // The price is that a read shows the state one cycle before its access edge,
  // never the effect of a write that completes on that same edge.
  always_ff @(posedge clock) begin
    if (reset) begin
      prdata_r <= 32'h0;
    end else if (ce) begin
      if (setup_ph && !pwrite) begin
        prdata_r <= rdata_nxt;
      end
    end
  end

  assign prdata = prdata_r;

  // Receive buffer counter.
  // A packet pulse that arrives while the clock enable is low is lost, so the
  // receive engine must not report packets into a frozen block.
  erbcs_buf_counter #(
    .CNT_W(CNT_W),
    .INC_W(INC_W)
  ) u_cnt (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .inc_valid(rx_packet_done),
    .inc_amount(rx_descriptors_used),
    .dec_req(dec_pulse),
    .clear_req(clr_cnt),
    .count(cnt),
    .at_max(cnt_max),
    .nonzero(cnt_nz)
  );

  // Activity flags.
  // Each flag lags its inputs by one registered cycle.
  erbcs_busy_flags u_busy (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .module_on(ctl_r[`ERBCS_CTL_ON_BIT]),
    .transaction_pending(transaction_pending),
    .tx_activity(tx_activity),
    .rx_activity(rx_activity),
    .module_active_flag(mod_flag),
    .transmit_active_flag(tx_flag),
    .receive_active_flag(rx_flag)
  );

  // Halt only under flow control; otherwise the DMA runs on and the count
  // simply stays saturated.
  assign rx_halt = ctl_r[`ERBCS_CTL_AFC_BIT] && cnt_max;

  // Outputs toward the controller.
  // The pending flag follows the count register directly, with no added lag.
  assign module_on = ctl_r[`ERBCS_CTL_ON_BIT];
  assign station_address = sta_r;
  assign rx_descriptor_start_address = rxst_r;
  assign packet_pending_flag = cnt_nz;

endmodule

// >>> verif/erbcs_props.sv
`timescale 1ns/10ps
// Port-level checks of bus ready, the receive buffer accounting and the station address, bound into the top module.
module erbcs_props #(
  parameter int INC_W = 4
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  // Receive side and status.
  input wire logic rx_packet_done,
  input wire logic [INC_W-1:0] rx_descriptors_used,
  input wire logic rx_halt,
  input wire logic [15:0] factory_station_address,
  input wire logic [15:0] station_address,
  input wire logic packet_pending_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // An accepted access; only writes may lower the count or move the station address.
  wire acc = psel && penable && ce;
  wire wr = acc && pwrite;
  wire good_strb = (pstrb == 4'hf) || (pstrb == 4'h3) || (pstrb == 4'hc);
  // A counted packet report with no software write beside it.
  sequence s_pkt;
    rx_packet_done && ce && (rx_descriptors_used != 0) && !wr;
  endsequence
  sequence s_start_write;
    wr && (paddr[7:4] == 4'h2) && (paddr[1:0] == 2'h0) && good_strb;
  endsequence
  a_pready_zero: assert property (acc |-> pready)
    else $error("access phase without ready");
  a_pkt_pends: assert property (s_pkt |=> packet_pending_flag)
    else $error("packet did not raise pending");
  a_pend_holds: assert property (packet_pending_flag && !wr |=> packet_pending_flag)
    else $error("pending dropped without software");
  a_halt_full: assert property (rx_halt |-> packet_pending_flag)
    else $error("halt with empty count");
  a_halt_stays: assert property (rx_halt && !wr |=> rx_halt)
    else $error("saturated count moved");
  a_start_clears: assert property (s_start_write |=> !packet_pending_flag && !rx_halt)
    else $error("start address write kept count");
  a_station_preset: assert property ($fell(reset) |->
    station_address == $past(factory_station_address))
    else $error("station not preset");
  a_station_hold: assert property (!wr |=> $stable(station_address))
    else $error("station moved without write");
  a_byte_ignored: assert property (wr && paddr[7:4] == 4'h3 && !good_strb
    |=> $stable(station_address))
    else $error("byte write reached station");
endmodule

bind erbcs_top erbcs_props #(.INC_W(INC_W)) erbcs_props_i (.clock, .reset, .ce, .psel,
  .penable, .pwrite, .paddr, .pstrb, .pready, .rx_packet_done, .rx_descriptors_used,
  .rx_halt, .factory_station_address, .station_address, .packet_pending_flag);

// >>> verif/erbcs_rx_dma.sv
`timescale 1ns/10ps
// Receive engine stand-in: one packet report per start, after a chosen gap.
module erbcs_rx_dma (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Requests from the bench.
  input wire logic start,
  input wire logic [3:0] gap,
  input wire logic [3:0] amount,
  // Toward the block.
  input wire logic rx_halt,
  output logic rx_packet_done,
  output logic [3:0] rx_descriptors_used,
  output logic busy
);
  logic [3:0] wait_r; // Cycles left before the report.
  logic [3:0] amt_r; // Descriptors the packet used.
  // Outside the pulse the count lines show garbage, so a sloppy sampler is caught.
  assign rx_descriptors_used = rx_packet_done ? amt_r : ~amt_r;
  // A waiting packet stalls for as long as the block halts reception.
  always_ff @(posedge clock) begin
    if (reset) begin
      busy <= 1'b0;
      rx_packet_done <= 1'b0;
      wait_r <= 4'h0;
      amt_r <= 4'h0;
    end else begin
      rx_packet_done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        wait_r <= gap;
        amt_r <= amount;
      end else if (busy && wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end else if (busy && !rx_halt) begin
        rx_packet_done <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule

// >>> verif/test_eth_rx_buffer_count_status.sv
`timescale 1ns/10ps
module test_eth_rx_buffer_count_status;
  // Bench-driven and observed signals.
  logic clock, reset, ce, psel, penable, pwrite, start, dma_busy, err;
  logic pready, pslverr, rx_packet_done, rx_halt, module_on, packet_pending_flag, irq;
  logic transaction_pending, tx_activity, rx_activity;
  logic [7:0] paddr;
  logic [3:0] pstrb, gap, amount, rx_descriptors_used;
  logic [31:0] pwdata, prdata, rd, lfsr, rx_descriptor_start_address;
  logic [15:0] factory, stn, station_address;
  int n_fail, compares, cnt;

  erbcs_top erbcs_top_i (.clock, .reset, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .factory_station_address(factory), .rx_packet_done,
    .rx_descriptors_used, .rx_halt, .rx_descriptor_start_address, .transaction_pending,
    .tx_activity, .rx_activity, .module_on, .station_address, .packet_pending_flag, .irq);
  erbcs_rx_dma erbcs_rx_dma_i (.clock, .reset, .start, .gap, .amount, .rx_halt,
    .rx_packet_done, .rx_descriptors_used, .busy(dma_busy));

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Expected status word for a count and the three activity flags.
  function automatic logic [31:0] stat(input int c, input logic m, input logic t,
      input logic r);
    return {8'h00, c[7:0], 8'h00, m, t, r, 5'h00};
  endfunction

  function automatic int sat(input int v);
    return (v > 255) ? 255 : v;
  endfunction

  function automatic void rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus transfer, entered just after an edge; an idle edge follows the release.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0000_0000, 4'hf);
    check(n, e, rd);
  endtask

  // Asks for one packet report and waits until the count has landed.
  task automatic pkt(input logic [3:0] g, input logic [3:0] n);
    start <= 1'b1;
    gap <= g;
    amount <= n;
    @(posedge clock);
    start <= 1'b0;
    @(posedge clock);
    repeat (40) if (dma_busy === 1'b1) @(posedge clock);
    repeat (2) @(posedge clock);
  endtask

  task automatic stop_test();
    $display("counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // A hang costs a mismatch and ends the run through the same closing task.
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    stop_test();
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    start = 1'b0;
    gap = 4'h0;
    amount = 4'h0;
    transaction_pending = 1'b0;
    tx_activity = 1'b0;
    rx_activity = 1'b0;
    n_fail = 0;
    compares = 0;
    cnt = 0;
    lfsr = 32'h92b0;
    rnd();
    factory = lfsr[15:0];
    stn = lfsr[15:0];
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    // The preset is taken in reset only, so a later change must not show.
    factory <= ~factory;
    rchk(8'h00, stat(0, 1'b0, 1'b0, 1'b0), "status reset");
    rchk(8'h30, {16'h0000, stn}, "station preset");
    rchk(8'h10, 32'h0000_0000, "control reset");
    apb(1'b0, 8'h70, 32'h0000_0000, 4'hf);
    check("unmapped error", 32'h1, {31'h0, err});
    $display("test reset done");
    // Station: byte write refused, halfword taken, aliases touch only ones.
    rnd();
    apb(1'b1, 8'h30, lfsr & 32'h0000_ffff, 4'h1);
    rchk(8'h30, {16'h0000, stn}, "station byte");
    apb(1'b1, 8'h30, lfsr & 32'h0000_ffff, 4'h3);
    stn = lfsr[15:0];
    rchk(8'h30, {16'h0000, stn}, "station half");
    check("station port", {16'h0000, stn}, {16'h0000, station_address});
    apb(1'b1, 8'h3c, 32'h0000_ff00, 4'hf);
    stn = stn ^ 16'hff00;
    rchk(8'h30, {16'h0000, stn}, "station invert");
    apb(1'b1, 8'h34, 32'h0000_000f, 4'hf);
    stn = stn & 16'hfff0;
    rchk(8'h30, {16'h0000, stn}, "station clear");
    apb(1'b1, 8'h38, 32'h0000_0081, 4'hf);
    stn = stn | 16'h0081;
    rchk(8'h30, {16'h0000, stn}, "station set");
    $display("test station done");
    // Random packets until the count saturates, flow control off.
    for (int i = 0; i < 80 && cnt < 255; i++) begin
      rnd();
      pkt(lfsr[3:0], lfsr[7:4] | 4'h1);
      cnt = sat(cnt + int'(lfsr[7:4] | 4'h1));
      rchk(8'h00, stat(cnt, 1'b0, 1'b0, 1'b0), "count");
    end
    pkt(4'h0, 4'hf);
    rchk(8'h00, stat(255, 1'b0, 1'b0, 1'b0), "saturated");
    check("no halt", 32'h0, {31'h0, rx_halt});
    $display("test count done");
    // Pending interrupt: raised, re-raised after a clear, then masked.
    apb(1'b1, 8'h58, 32'h0000_0001, 4'hf);
    check("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h60, 32'h0000_0001, 4'hf);
    check("irq kept", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h54, 32'h0000_0001, 4'hf);
    check("irq masked", 32'h0, {31'h0, irq});
    // Decrement, then a decrement meeting a packet report on the same edge.
    apb(1'b1, 8'h18, 32'h0000_0001, 4'hf);
    rchk(8'h00, stat(254, 1'b0, 1'b0, 1'b0), "decrement");
    start <= 1'b1;
    amount <= 4'h3;
    gap <= 4'h0;
    @(posedge clock);
    start <= 1'b0;
    apb(1'b1, 8'h18, 32'h0000_0001, 4'hf);
    rchk(8'h00, stat(254, 1'b0, 1'b0, 1'b0), "inc with dec");
    // Start address write empties the count; decrement at zero stays put.
    rnd();
    apb(1'b1, 8'h20, lfsr, 4'hf);
    check("start addr", lfsr & 32'hffff_fffc, rx_descriptor_start_address);
    rchk(8'h00, stat(0, 1'b0, 1'b0, 1'b0), "start clears");
    check("pending low", 32'h0, {31'h0, packet_pending_flag});
    apb(1'b1, 8'h18, 32'h0000_0001, 4'hf);
    rchk(8'h00, stat(0, 1'b0, 1'b0, 1'b0), "no underflow");
    ce <= 1'b0;
    pkt(4'h0, 4'h2);
    ce <= 1'b1;
    rchk(8'h00, stat(0, 1'b0, 1'b0, 1'b0), "frozen count");
    apb(1'b1, 8'h60, 32'h0000_0007, 4'hf);
    apb(1'b1, 8'h58, 32'h0000_0001, 4'hf);
    check("irq cleared", 32'h0, {31'h0, irq});
    $display("test decrement done");
    // Flow control: full count halts the engine until software makes room.
    apb(1'b1, 8'h18, 32'h0000_0002, 4'hf);
    for (int i = 0; i < 17; i++) pkt(4'h0, 4'hf);
    check("halted", 32'h1, {31'h0, rx_halt});
    start <= 1'b1;
    amount <= 4'h2;
    @(posedge clock);
    start <= 1'b0;
    repeat (6) @(posedge clock);
    check("engine held", 32'h1, {31'h0, dma_busy});
    apb(1'b1, 8'h18, 32'h0000_0001, 4'hf);
    repeat (6) @(posedge clock);
    rchk(8'h00, stat(255, 1'b0, 1'b0, 1'b0), "resumed");
    check("halted again", 32'h1, {31'h0, rx_halt});
    $display("test flow control done");
    // Activity flags while on, after switching off, and once idle.
    apb(1'b1, 8'h18, 32'h0000_8000, 4'hf);
    check("module on", 32'h1, {31'h0, module_on});
    tx_activity <= 1'b1;
    repeat (2) @(posedge clock);
    rchk(8'h00, stat(255, 1'b1, 1'b1, 1'b0), "tx only");
    tx_activity <= 1'b0;
    rx_activity <= 1'b1;
    repeat (2) @(posedge clock);
    rchk(8'h00, stat(255, 1'b1, 1'b0, 1'b1), "rx only");
    transaction_pending <= 1'b1;
    apb(1'b1, 8'h14, 32'h0000_8000, 4'hf);
    rchk(8'h00, stat(255, 1'b1, 1'b0, 1'b0), "off busy");
    transaction_pending <= 1'b0;
    repeat (2) @(posedge clock);
    rchk(8'h00, stat(255, 1'b0, 1'b0, 1'b0), "off idle");
    $display("test activity done");
    stop_test();
  end
endmodule
